/* File: hw/mpt_panel_timing.sv */
// Monochrome 4-bit panel timing, power sequencing and APB register file
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// RULE1 - Line period: (width+1)*8 plus (blank+4)*8
// RULE2 - Frame pulse holds 9 after line fall
// RULE3 - Frame pulse sets up line period minus 9
// RULE4 - Line pulse stays high 9 pixel clocks
// RULE5 - AC bias toggles 1+ clock after line rise
// RULE6 - Shift clock period 4: low 2, high 2
// RULE7 - Nibble on upper lines, stable around fall
// RULE8 - First shift rise 23 after line fall
// RULE9 - First shift fall 2 after first rise
// RULE10 - Last shift fall to line rise: blank*8+2
// RULE11 - Last shift fall to line fall: blank*8+11
// RULE12 - Display enable activates outputs within one frame
// RULE13 - Power comes up with signals, same frame
// RULE14 - Force-off: sleep toggles signals within a frame
// RULE15 - Sleep drops power, signals run 127 frames
// RULE16 - Wake restores signals and power together
// RULE17 - Force-off bit switches power within a frame
// RULE18 - Software sets divide bit above 25 MHz
// RULE19 - All timing from one pixel clock enable
module mpt_panel_timing (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hardware_sleep_input,
  output logic line_pulse_out,
  output logic frame_pulse_out,
  output logic shift_clock_out,
  output logic [7:0] panel_data_out,
  output logic panel_data_valid,
  output logic ac_bias_toggle,
  output logic panel_power_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Drain keeps the panel scanned with power off so it discharges cleanly
  typedef enum logic [1:0] {
    MPT_PWR_DARK = 2'b00,
    MPT_PWR_LIVE = 2'b01,
    MPT_PWR_DRAIN = 2'b10
  } mpt_pwr_t;

  typedef struct packed {
    logic clk_div;
    logic disp_en;
    logic [mpt_pkg::HW_W-1:0] hwidth;
    logic [mpt_pkg::HB_W-1:0] hblank;
    logic force_off;
    logic [mpt_pkg::VL_W-1:0] vlines;
    logic [31:0] pattern;
    logic [31:0] rdata;
    logic slverr;
    logic [mpt_pkg::H_W-1:0] hcnt;
    logic [mpt_pkg::VL_W-1:0] vcnt;
    logic sig_on;
    logic pwr_on;
    mpt_pwr_t pst;
    logic [mpt_pkg::SLP_W-1:0] slp_cnt;
    logic lp;
    logic fp;
    logic sc;
    logic [7:0] dat;
    logic dv;
    logic ac;
  } mpt_state_t;

  mpt_state_t q_r;
  mpt_state_t q_nxt;
  logic pix_en;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] idx);
    addr_is = (addr == 8'(idx << 2));
  endfunction

  function automatic logic [3:0] nib_sel(input logic [31:0] pat, input logic [2:0] idx);
    nib_sel = pat[{idx, 2'b00} +: 4];
  endfunction

  function automatic logic addr_known(input logic [7:0] addr);
    addr_known = addr_is(addr, mpt_pkg::IDX_CLK_CFG) || addr_is(addr, mpt_pkg::IDX_MODE) ||
                 addr_is(addr, mpt_pkg::IDX_HWIDTH) || addr_is(addr, mpt_pkg::IDX_HBLANK) ||
                 addr_is(addr, mpt_pkg::IDX_PWR_CTRL) || addr_is(addr, mpt_pkg::IDX_VLINES) ||
                 addr_is(addr, mpt_pkg::IDX_PATTERN) || addr_is(addr, mpt_pkg::IDX_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // Pixel clock enable
  // ----------------------------------------------------------------
  // Above 25 MHz core clock software must set the divide bit [RULE18]
  mpt_pix_en u_pix_en (
    .clk(clk),
    .rst_b(rst_b),
    .div2(q_r.clk_div),
    .pix_en(pix_en)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [mpt_pkg::H_W-1:0] act_len;
  logic [mpt_pkg::H_W-1:0] line_len;
  logic [mpt_pkg::H_W-1:0] rel;
  logic line_end;
  logic last_line;
  logic frame_tick;
  logic act;
  logic wr;

  always_comb begin
    q_nxt = q_r;
    // Active pixels take (width+1)*8, blanking (blank+4)*8 [RULE1]
    act_len = mpt_pkg::H_W'({4'h0, q_r.hwidth} + 11'h001) * mpt_pkg::H_W'(mpt_pkg::PIX_UNIT);
    line_len = act_len +
               mpt_pkg::H_W'({6'h00, q_r.hblank} + mpt_pkg::H_W'(mpt_pkg::BLANK_ADD)) *
               mpt_pkg::H_W'(mpt_pkg::PIX_UNIT); // [RULE1]
    line_end = (q_r.hcnt == line_len - 11'h001);
    last_line = (q_r.vcnt == q_r.vlines);
    // Power decisions are taken on the last line just before the frame pulse
    // rises, so outputs never start or stop in the middle of a frame pulse.
    frame_tick = pix_en && last_line &&
                 (q_r.hcnt == mpt_pkg::H_W'(mpt_pkg::LP_WIDTH - 1)); // [RULE19]
    rel = q_r.hcnt - mpt_pkg::ACT_START;
    act = (q_r.hcnt >= mpt_pkg::ACT_START) && (rel < act_len);
    wr = psel && penable && pwrite;

    // APB: read data captured in the setup cycle, so pready can stay high
    if (psel && !penable) begin
      q_nxt.slverr = !addr_known(paddr);
      q_nxt.rdata = 32'h0000_0000;
      if (addr_is(paddr, mpt_pkg::IDX_CLK_CFG)) begin
        q_nxt.rdata[mpt_pkg::CLK_DIV_BIT] = q_r.clk_div;
      end
      if (addr_is(paddr, mpt_pkg::IDX_MODE)) begin
        q_nxt.rdata[mpt_pkg::MODE_EN_BIT] = q_r.disp_en;
      end
      if (addr_is(paddr, mpt_pkg::IDX_HWIDTH)) begin
        q_nxt.rdata[mpt_pkg::HW_W-1:0] = q_r.hwidth;
      end
      if (addr_is(paddr, mpt_pkg::IDX_HBLANK)) begin
        q_nxt.rdata[mpt_pkg::HB_W-1:0] = q_r.hblank;
      end
      if (addr_is(paddr, mpt_pkg::IDX_PWR_CTRL)) begin
        q_nxt.rdata[mpt_pkg::PWR_FORCE_BIT] = q_r.force_off;
      end
      if (addr_is(paddr, mpt_pkg::IDX_VLINES)) begin
        q_nxt.rdata[mpt_pkg::VL_W-1:0] = q_r.vlines;
      end
      if (addr_is(paddr, mpt_pkg::IDX_PATTERN)) begin
        q_nxt.rdata = q_r.pattern;
      end
      if (addr_is(paddr, mpt_pkg::IDX_STATUS)) begin
        q_nxt.rdata = {12'h000, q_r.vcnt, q_r.slp_cnt, hardware_sleep_input,
                       q_r.pwr_on, q_r.sig_on};
      end
    end

    if (wr) begin
      if (addr_is(paddr, mpt_pkg::IDX_CLK_CFG)) begin
        q_nxt.clk_div = pwdata[mpt_pkg::CLK_DIV_BIT];
      end
      if (addr_is(paddr, mpt_pkg::IDX_MODE)) begin
        q_nxt.disp_en = pwdata[mpt_pkg::MODE_EN_BIT];
      end
      if (addr_is(paddr, mpt_pkg::IDX_HWIDTH)) begin
        q_nxt.hwidth = pwdata[mpt_pkg::HW_W-1:0];
      end
      if (addr_is(paddr, mpt_pkg::IDX_HBLANK)) begin
        q_nxt.hblank = pwdata[mpt_pkg::HB_W-1:0];
      end
      if (addr_is(paddr, mpt_pkg::IDX_PWR_CTRL)) begin
        q_nxt.force_off = pwdata[mpt_pkg::PWR_FORCE_BIT];
      end
      if (addr_is(paddr, mpt_pkg::IDX_VLINES)) begin
        q_nxt.vlines = pwdata[mpt_pkg::VL_W-1:0];
      end
      if (addr_is(paddr, mpt_pkg::IDX_PATTERN)) begin
        q_nxt.pattern = pwdata;
      end
    end

    // ----------------------------------------------------------------
    // Horizontal and vertical counters, always running so that frame
    // boundaries exist even while the panel is dark
    // ----------------------------------------------------------------
    if (pix_en) begin
      if (line_end || (q_r.hcnt >= line_len)) begin
        q_nxt.hcnt = '0;
        q_nxt.vcnt = (last_line || (q_r.vcnt > q_r.vlines)) ? '0 : q_r.vcnt + 10'h001;
      end else begin
        q_nxt.hcnt = q_r.hcnt + 11'h001;
      end
      // Toggle once per line, clear of the line pulse rising edge [RULE5]
      if (q_r.hcnt == mpt_pkg::H_W'(mpt_pkg::MOD_DELAY) && q_r.sig_on) begin
        q_nxt.ac = ~q_r.ac;
      end
    end

    // ----------------------------------------------------------------
    // Power sequencing, once per frame
    // ----------------------------------------------------------------
    if (frame_tick) begin
      case (q_r.pst)
        MPT_PWR_DARK: begin
          if (q_r.disp_en && !hardware_sleep_input) begin
            // Display on: signals, and power with them unless force_off is set [RULE12] [RULE13] [RULE14] [RULE16]
            q_nxt.pst = MPT_PWR_LIVE;
            q_nxt.sig_on = 1'b1;
            q_nxt.pwr_on = !q_r.force_off; // [RULE17]
            q_nxt.slp_cnt = '0;
          end
        end
        MPT_PWR_LIVE: begin
          if (!q_r.disp_en || (hardware_sleep_input && q_r.force_off)) begin
            q_nxt.pst = MPT_PWR_DARK;
            q_nxt.sig_on = 1'b0; // [RULE14]
            q_nxt.pwr_on = 1'b0;
          end else if (hardware_sleep_input) begin
            // Count starts at one: the frame now beginning is the first unpowered one
            q_nxt.pst = MPT_PWR_DRAIN;
            q_nxt.pwr_on = 1'b0; // [RULE15]
            q_nxt.slp_cnt = 7'h01;
          end else begin
            q_nxt.pwr_on = !q_r.force_off; // [RULE17]
          end
        end
        MPT_PWR_DRAIN: begin
          if (!q_r.disp_en || (hardware_sleep_input && q_r.force_off)) begin
            q_nxt.pst = MPT_PWR_DARK;
            q_nxt.sig_on = 1'b0;
          end else if (!hardware_sleep_input) begin
            // Wake: power returns while the signals are still running [RULE16]
            q_nxt.pst = MPT_PWR_LIVE;
            q_nxt.pwr_on = !q_r.force_off;
            q_nxt.slp_cnt = '0;
          end else if (q_r.slp_cnt == mpt_pkg::SLEEP_FRAMES) begin
            q_nxt.pst = MPT_PWR_DARK;
            q_nxt.sig_on = 1'b0; // [RULE15]
          end else begin
            q_nxt.slp_cnt = q_r.slp_cnt + 7'h01;
          end
        end
        default: begin
          q_nxt.pst = MPT_PWR_DARK;
          q_nxt.sig_on = 1'b0;
          q_nxt.pwr_on = 1'b0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Panel outputs, registered from the counters
    // ----------------------------------------------------------------
    q_nxt.lp = q_r.sig_on && (q_r.hcnt < mpt_pkg::H_W'(mpt_pkg::LP_WIDTH)); // [RULE4]
    // High from the last line's line-fall to 9 after first line's fall [RULE2] [RULE3]
    q_nxt.fp = q_r.sig_on &&
               ((last_line && q_r.hcnt >= mpt_pkg::H_W'(mpt_pkg::LP_WIDTH)) ||
                (q_r.vcnt == '0 &&
                 q_r.hcnt < mpt_pkg::H_W'(mpt_pkg::LP_WIDTH + mpt_pkg::FP_HOLD)));
    // Active starts 23 after line fall, ends blank*8 before line rise; last shift fall is blank*8+2 before it
    // [RULE8] [RULE10] [RULE11]
    q_nxt.dv = q_r.sig_on && act;
    q_nxt.sc = q_r.sig_on && act && !rel[1]; // [RULE6] [RULE9]
    if (!q_r.sig_on || !act) begin
      q_nxt.dat = 8'h00;
    end else if (rel[1:0] == 2'b00) begin
      // Change on the shift rise: stable 2 before and 2 after its fall [RULE7]
      q_nxt.dat = {nib_sel(q_r.pattern, rel[4:2]), 4'h0};
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
      q_r.hwidth <= mpt_pkg::HWIDTH_RST;
      q_r.hblank <= mpt_pkg::HBLANK_RST;
      q_r.vlines <= mpt_pkg::VLINES_RST;
      q_r.pattern <= mpt_pkg::PATTERN_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = q_r.rdata;
  assign pslverr = q_r.slverr && psel && penable;
  assign line_pulse_out = q_r.lp;
  assign frame_pulse_out = q_r.fp;
  assign shift_clock_out = q_r.sc;
  assign panel_data_out = q_r.dat;
  assign panel_data_valid = q_r.dv;
  assign ac_bias_toggle = q_r.ac;
  assign panel_power_enable = q_r.pwr_on;

endmodule

/* File: hw/mpt_pix_en.sv */
// Pixel clock enable: one pulse per core clock or per two core clocks
`timescale 1ns/1ps
module mpt_pix_en (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic div2,
  output logic pix_en
);

  typedef struct packed {
    logic phase;
  } mpt_div_st_t;

  mpt_div_st_t q_r;
  mpt_div_st_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.phase = div2 ? ~q_r.phase : 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Every tick of the panel timing comes from this one enable [RULE19]
  assign pix_en = div2 ? q_r.phase : 1'b1;

endmodule

/* File: hw/mpt_pkg.sv */
// Package: register map, field positions, reset values and panel timing constants
package mpt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CLK_CFG = 8'h02;
  localparam logic [7:0] IDX_MODE = 8'h03;
  localparam logic [7:0] IDX_HWIDTH = 8'h04;
  localparam logic [7:0] IDX_HBLANK = 8'h08;
  localparam logic [7:0] IDX_PWR_CTRL = 8'h0A;
  localparam logic [7:0] IDX_VLINES = 8'h0C;
  localparam logic [7:0] IDX_PATTERN = 8'h10;
  localparam logic [7:0] IDX_STATUS = 8'h11;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CLK_DIV_BIT = 4;
  localparam int MODE_EN_BIT = 0;
  localparam int PWR_FORCE_BIT = 0;
  localparam int HW_W = 7;
  localparam int HB_W = 5;
  localparam int VL_W = 10;
  localparam int H_W = 11;
  localparam int SLP_W = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [HW_W-1:0] HWIDTH_RST = 7'h27;
  localparam logic [HB_W-1:0] HBLANK_RST = 5'h00;
  localparam logic [VL_W-1:0] VLINES_RST = 10'h0EF;
  localparam logic [31:0] PATTERN_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Panel timing in pixel clocks
  // ----------------------------------------------------------------
  localparam int PIX_UNIT = 8;
  localparam int BLANK_ADD = 4;
  localparam int LP_WIDTH = 9;
  localparam int FP_HOLD = 9;
  localparam int MOD_DELAY = 1;
  localparam int SHIFT_LEAD = 23;
  localparam logic [H_W-1:0] ACT_START = H_W'(LP_WIDTH + SHIFT_LEAD);
  localparam logic [SLP_W-1:0] SLEEP_FRAMES = 7'h7F;

endpackage

/* File: sim/mono_panel_timing_power_seq_tb_top.sv */
// Self-checking bench for panel timing and power sequencing
`timescale 1ns/1ps
module mono_panel_timing_power_seq_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slp = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, pat;
  logic pready, pslverr, lp, fp, sh, dv, ac, pwr, nev, pev, act, fo;
  logic [7:0] pd;
  logic [3:0] nib;
  logic [15:0] per;
  logic [32:0] q_rd[$];
  logic [15:0] q_per[$];
  logic [3:0] q_nib[$];
  int n_errors = 0, compares = 0, cyc = 0, idle = 0, lv = 64, n, b, f;
  always #10 clk = ~clk;
  assign act = idle < lv + 2;
  mpt_panel_timing mpt_panel_timing_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hardware_sleep_input(slp), .line_pulse_out(lp), .frame_pulse_out(fp),
    .shift_clock_out(sh), .panel_data_out(pd), .panel_data_valid(dv), .ac_bias_toggle(ac),
    .panel_power_enable(pwr));
  mpt_panel_model mpt_panel_model_i (.clk(clk), .line_pulse_out(lp), .shift_clock_out(sh),
    .panel_data_out(pd), .nib_ev(nev), .nib(nib), .per_ev(pev), .per(per));
  task automatic finish_test();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // --------------------------------------------------------------
  // Result watcher: oldest note is matched against each result
  // --------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    idle <= (lp === 1'b1) ? 0 : idle + 1;
    if (psel && penable && pready === 1'b1 && !pwrite && q_rd.size() > 0) begin
      cmp({pslverr, prdata}, q_rd.pop_front());
    end
    if (nev === 1'b1 && q_nib.size() > 0) begin
      cmp(33'(nib), 33'(q_nib.pop_front()));
    end
    if (pev === 1'b1 && q_per.size() > 0) begin
      cmp(33'(per), 33'(q_per.pop_front()));
    end
    if (cyc > 100000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [32:0] e);
    q_rd.push_back(e);
    xfer(idx, 1'b0, 32'h0000_0000);
  endtask
  // Power when p is set, otherwise line activity
  task automatic await(input logic p, input logic v, input int lim);
    n = 0;
    while (((p ? pwr : act) !== v) && n < lim) begin
      @(posedge clk);
      n++;
    end
    cmp(33'(p ? pwr : act), 33'(v));
  endtask
  task automatic drain();
    n = 0;
    while (q_nib.size() + q_per.size() > 0 && n < 8 * lv) begin
      @(posedge clk);
      n++;
    end
    cmp(33'(q_nib.size() + q_per.size()), 33'h0);
  endtask
  initial begin
    void'($urandom(88826));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(mpt_pkg::IDX_HWIDTH, {26'h0, mpt_pkg::HWIDTH_RST});
    rd(mpt_pkg::IDX_HBLANK, {28'h0, mpt_pkg::HBLANK_RST});
    rd(mpt_pkg::IDX_VLINES, {23'h0, mpt_pkg::VLINES_RST});
    rd(mpt_pkg::IDX_PATTERN, {1'b0, mpt_pkg::PATTERN_RST});
    rd(8'h3F, 33'h1_0000_0000);
    $display("test registers done");
    // Eight shifts per line, so the nibble order is the same per line or per frame
    b = $urandom_range(3, 0);
    pat = $urandom;
    lv = 32 + (b + 4) * 8;
    xfer(mpt_pkg::IDX_HWIDTH, 1'b1, 32'h0000_0003);
    xfer(mpt_pkg::IDX_HBLANK, 1'b1, 32'(b));
    xfer(mpt_pkg::IDX_VLINES, 1'b1, 32'h0000_0003);
    xfer(mpt_pkg::IDX_PATTERN, 1'b1, pat);
    rd(mpt_pkg::IDX_PATTERN, {1'b0, pat});
    for (int k = 0; k < 32; k++) q_nib.push_back(pat[4 * (k % 8) +: 4]);
    xfer(mpt_pkg::IDX_MODE, 1'b1, 32'h0000_0001);
    await(1'b1, 1'b1, 4 * lv + 8);
    drain();
    q_per.push_back(16'(lv));
    drain();
    xfer(mpt_pkg::IDX_CLK_CFG, 1'b1, 32'h0000_0010);
    repeat (4 * lv) @(posedge clk);
    q_per.push_back(16'(2 * lv));
    drain();
    xfer(mpt_pkg::IDX_CLK_CFG, 1'b1, 32'h0000_0000);
    repeat (4 * lv) @(posedge clk);
    $display("test timing done");
    slp <= 1'b1;
    await(1'b1, 1'b0, 4 * lv + 8);
    f = 0;
    fo = fp;
    while (act === 1'b1) begin
      @(posedge clk);
      f = f + ((fp === 1'b1 && fo === 1'b0) ? 1 : 0);
      fo = fp;
    end
    cmp(33'(f), 33'(mpt_pkg::SLEEP_FRAMES));
    slp <= 1'b0;
    await(1'b1, 1'b1, 4 * lv + 8);
    await(1'b0, 1'b1, lv);
    $display("test sleep done");
    xfer(mpt_pkg::IDX_PWR_CTRL, 1'b1, 32'h0000_0001);
    await(1'b1, 1'b0, 4 * lv + 8);
    slp <= 1'b1;
    await(1'b0, 1'b0, 5 * lv + 8);
    slp <= 1'b0;
    await(1'b0, 1'b1, 5 * lv + 8);
    cmp(33'(pwr), 33'h0);
    xfer(mpt_pkg::IDX_PWR_CTRL, 1'b1, 32'h0000_0000);
    await(1'b1, 1'b1, 4 * lv + 8);
    $display("test force-off done");
    finish_test();
  end
endmodule

/* File: sim/mpt_panel_model.sv */
// Panel model: latches nibbles on shift falls and measures line periods
`timescale 1ns/1ps
module mpt_panel_model (
  input wire logic clk,
  input wire logic line_pulse_out,
  input wire logic shift_clock_out,
  input wire logic [7:0] panel_data_out,
  output logic nib_ev,
  output logic [3:0] nib,
  output logic per_ev,
  output logic [15:0] per
);
  logic sh_q = 1'b0;
  logic ln_q = 1'b0;
  logic [15:0] cnt = 16'h0000;
  // The panel only sees the upper lines; it latches them as the shift clock falls
  always @(posedge clk) begin
    sh_q <= shift_clock_out;
    ln_q <= line_pulse_out;
    nib_ev <= sh_q && !shift_clock_out;
    nib <= panel_data_out[7:4];
    per_ev <= line_pulse_out && !ln_q;
    per <= cnt;
    cnt <= (line_pulse_out && !ln_q) ? 16'h0001 : cnt + 16'h0001;
  end
endmodule

/* File: sim/mpt_panel_timing_asserts.sv */
// Checker for the panel timing outputs
`timescale 1ns/1ps
module mpt_panel_timing_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic line_pulse_out,
  input wire logic frame_pulse_out,
  input wire logic shift_clock_out,
  input wire logic [7:0] panel_data_out,
  input wire logic panel_data_valid,
  input wire logic ac_bias_toggle,
  input wire logic panel_power_enable
);
  logic [15:0] lc_r, prd_r, pprd_r, fc_r, gc_r;
  logic first_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Periods are measured in core clocks, so they hold as minima in divide mode too
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lc_r <= 16'h0000;
      prd_r <= 16'h0000;
      pprd_r <= 16'h0000;
      fc_r <= 16'h0000;
      gc_r <= 16'h0000;
      first_r <= 1'b0;
    end else begin
      lc_r <= $rose(line_pulse_out) ? 16'h0001 : lc_r + 16'h0001;
      prd_r <= $rose(line_pulse_out) ? lc_r : prd_r;
      pprd_r <= $rose(line_pulse_out) ? prd_r : pprd_r;
      fc_r <= $rose(frame_pulse_out) ? 16'h0001 : fc_r + 16'h0001;
      gc_r <= $fell(line_pulse_out) ? 16'h0001 : gc_r + 16'h0001;
      first_r <= $fell(line_pulse_out) | (first_r & !$rose(shift_clock_out));
    end
  end
  chk_line_width: assert property (
    $rose(line_pulse_out) |-> line_pulse_out [*8] ##1 line_pulse_out) else $error("line short");
  chk_shift_high: assert property (
    $rose(shift_clock_out) |-> shift_clock_out [*2]) else $error("shift high short");
  chk_shift_low: assert property (
    $fell(shift_clock_out) |-> !shift_clock_out [*2]) else $error("shift low short");
  chk_nibble_stable: assert property (
    $fell(shift_clock_out) |-> $stable(panel_data_out) [*2]) else $error("data moved");
  chk_low_nibble: assert property (
    panel_data_out[3:0] == 4'h0) else $error("low lines driven");
  chk_shift_lead: assert property (
    $rose(shift_clock_out) && first_r |-> gc_r >= 16'h0017) else $error("shift too early");
  chk_bias_delay: assert property (
    $rose(line_pulse_out) |-> $stable(ac_bias_toggle)) else $error("bias moved early");
  chk_bias_toggle: assert property (
    $rose(line_pulse_out) |-> ##[1:8] $changed(ac_bias_toggle)) else $error("bias not toggled");
  chk_valid_shift: assert property (
    shift_clock_out |-> panel_data_valid) else $error("shift outside valid");
  chk_valid_line: assert property (
    line_pulse_out |-> !panel_data_valid && panel_data_out == 8'h00)
    else $error("valid during line pulse");
  chk_frame_hold: assert property (
    $fell(line_pulse_out) && frame_pulse_out && $past(frame_pulse_out)
    |-> frame_pulse_out [*8] ##1 frame_pulse_out) else $error("frame hold short");
  chk_frame_setup: assert property (
    $fell(line_pulse_out) && frame_pulse_out && $past(frame_pulse_out) && prd_r == pprd_r
    |-> fc_r + 16'h0009 >= prd_r) else $error("frame setup short");
  chk_power_frame: assert property (
    $rose(panel_power_enable) |-> ##[0:1] frame_pulse_out) else $error("power off frame");
endmodule

bind mpt_panel_timing mpt_panel_timing_chk mpt_panel_timing_chk_i (.clk(clk), .rst_b(rst_b),
  .line_pulse_out(line_pulse_out), .frame_pulse_out(frame_pulse_out),
  .shift_clock_out(shift_clock_out), .panel_data_out(panel_data_out),
  .panel_data_valid(panel_data_valid),
  .ac_bias_toggle(ac_bias_toggle), .panel_power_enable(panel_power_enable));
